// ---- logic/ocm_cfg.svh ----
// register map, field positions and status bit positions of the compare timer
// assumes a 32-bit apb slave with byte addresses, one word per register
//
// What this block does
// RULE_01: ch0 pin A: port, compare output, clock
// RULE_02: other pins: port or compare output each
// RULE_03: interrupt pin: port, cutoff input, interrupt
// RULE_04: counter read returns current count
// RULE_05: lockstep off: write touches one counter
// RULE_06: lockstep on: write loads both counters
// RULE_07: match drives low, high or toggles
// RULE_08: initial level holds until first match
// RULE_09: counter clears on overflow or A match
// RULE_10: C and D may steer pins A, B
// RULE_11: any pin combination may be compare output
// RULE_12: stop-source 1: only software write stops
// RULE_13: stop-source 0: A match clears start bit
// RULE_14: software writes start register as whole byte
// RULE_15: count on divided, fast or external clock
// RULE_16: writing start bit 1 begins counting
// RULE_17: stopped channel holds its pin levels
// RULE_18: match and overflow raise interrupt request
// RULE_19: 16-bit counter wraps and flags overflow
`ifndef OCM_CFG_SVH
`define OCM_CFG_SVH
// ***************************************************
// register offsets
// ***************************************************
`define OCM_A_START 8'h00
`define OCM_A_MODE  8'h04
`define OCM_A_PIO   8'h08
`define OCM_A_CTRL0 8'h10
`define OCM_A_CTRL1 8'h14
`define OCM_A_ACT0  8'h18
`define OCM_A_ACT1  8'h1C
`define OCM_A_STAT0 8'h20
`define OCM_A_STAT1 8'h24
`define OCM_A_CNT0  8'h28
`define OCM_A_CNT1  8'h2C
`define OCM_GR_SEL  7:5
`define OCM_GR_TAG  3'h2
`define OCM_GR_CH   4
`define OCM_GR_IDX  3:2
// ***************************************************
// field positions
// ***************************************************
`define OCM_F_START   1:0
`define OCM_F_STOPSEL 3:2
`define OCM_F_SYNC    0
`define OCM_F_EIROLE  2:1
`define OCM_F_DIR     7:0
`define OCM_F_DAT     15:8
`define OCM_F_PIN     23:16
`define OCM_F_EIPIN   24
`define OCM_F_CKS     2:0
`define OCM_F_EDGE    3
`define OCM_F_CLRA    4
`define OCM_F_INIT    8:5
`define OCM_F_PEN     12:9
`define OCM_F_PEN_LO  9
`define OCM_F_USE_LO  13
`define OCM_F_EXTCK   15
`define OCM_CTRL_W    16
`define OCM_ST_OVF    4
`define OCM_ST_EXT    5
`endif

// ---- logic/ocm_pkg.sv ----
// types shared by the compare timer
// assumes ocm_cfg.svh holds all register offsets and field positions; action, source and pin role codes are the enums here
package ocm_pkg;
   // level change on a compare match
   typedef enum logic [1:0] {
      ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE
   } ocm_act_type;
   // count source selection
   typedef enum logic [2:0] {
      CKS_DIV1, CKS_DIV2, CKS_DIV4, CKS_DIV8, CKS_DIV32, CKS_EXT, CKS_FAST
   } ocm_cks_type;
   // role of the external interrupt pin
   typedef enum logic [1:0] {
      EI_PORT, EI_CUTOFF, EI_INT
   } ocm_ei_type;
endpackage

// ---- logic/ocm_timer.sv ----
// two-channel 16-bit output compare timer with apb register access
// assumes pins and fast clock tick are synchronous to ref_clk
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ocm_cfg.svh"
module ocm_timer #(
   parameter int CW = 16                   // counter width
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [7:0]    pinIn,       // pin levels, ch*4+pin
   input  wire logic          extIntIn,    // external interrupt pin
   input  wire logic          fastOscTick, // fast oscillator pulse
   output logic      [7:0]    pinOut,
   output logic      [7:0]    pinOe,
   output logic      [1:0]    irqReq       // per channel request
);
   // ***************************************************
   // state
   // ***************************************************
   logic                    start_r [2];     // count-start bits
   logic [1:0]              stopSel_r;       // stop-source select
   logic                    lockstep_r;      // both counters written
   logic [1:0]              extRole_r;       // interrupt pin role
   logic [7:0]              pioDir_r;        // port direction
   logic [7:0]              pioDat_r;        // port data
   logic [`OCM_CTRL_W-1:0]  ctrl_r [2];      // channel control
   logic [7:0]              act_r [2];       // match actions
   logic [5:0]              stat_r [2];      // sticky events
   logic [CW-1:0]           cnt_r [2];       // counters
   logic [CW-1:0]           gr_r [2][4];     // general registers
   logic [3:0]              lvl_r [2];       // compare levels
   logic [4:0]              pre_r;           // prescaler
   logic                    extPrev_r;       // clock pin history
   logic                    eiPrev_r;        // interrupt pin history
   logic                    wr;
   logic                    setup;
   logic                    extEdge;
   logic                    eiEvent;
   logic                    cutoff;
   logic [31:0]             rdData;
   logic                    rdErr;

   // ***************************************************
   // helpers
   // ***************************************************
   // new level for a match action
   function automatic logic applyAct(input logic cur,
                                     input logic [1:0] act);
      case (act)
         ocm_pkg::ACT_LOW:    applyAct = 1'b0;
         ocm_pkg::ACT_HIGH:   applyAct = 1'b1;
         ocm_pkg::ACT_TOGGLE: applyAct = ~cur;
         default:             applyAct = cur;
      endcase
   endfunction
   // count tick for the selected source
   function automatic logic srcTick(input logic [2:0] sel,
                                    input logic [4:0] pre,
                                    input logic ext,
                                    input logic fast);
      case (sel)
         ocm_pkg::CKS_DIV1:  srcTick = 1'b1;
         ocm_pkg::CKS_DIV2:  srcTick = pre[0];
         ocm_pkg::CKS_DIV4:  srcTick = &pre[1:0];
         ocm_pkg::CKS_DIV8:  srcTick = &pre[2:0];
         ocm_pkg::CKS_DIV32: srcTick = &pre;
         ocm_pkg::CKS_EXT:   srcTick = ext;
         ocm_pkg::CKS_FAST:  srcTick = fast;
         default:            srcTick = 1'b0;
      endcase
   endfunction
   // general register address decode
   function automatic logic isGr(input logic [7:0] a, input int ch,
                                 input int idx);
      isGr = a[`OCM_GR_SEL] == `OCM_GR_TAG &&
             a[`OCM_GR_CH] == ch[0] && a[`OCM_GR_IDX] == idx[1:0];
   endfunction

   // ***************************************************
   // apb slave
   // ***************************************************
   // one access cycle, no wait states
   assign setup = psel & ~penable;
   assign wr    = psel & penable & pwrite & pready;
   // answer prepared in setup, shown in access
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         prdata  <= setup ? rdData : 32'h0;
         pslverr <= setup & rdErr;
      end
   end
   // read mux; unmapped words answer with an error
   always_comb begin
      rdData = 32'h0;
      rdErr  = 1'b0;
      case (paddr)
         `OCM_A_START: begin
            rdData[`OCM_F_START]   = {start_r[1], start_r[0]};
            rdData[`OCM_F_STOPSEL] = stopSel_r;
         end
         `OCM_A_MODE: begin
            rdData[`OCM_F_SYNC]   = lockstep_r;
            rdData[`OCM_F_EIROLE] = extRole_r;
         end
         `OCM_A_PIO: begin
            rdData[`OCM_F_DIR]   = pioDir_r;
            rdData[`OCM_F_DAT]   = pioDat_r;
            rdData[`OCM_F_PIN]   = pinIn;
            rdData[`OCM_F_EIPIN] = extIntIn;
         end
         `OCM_A_CTRL0: rdData[`OCM_CTRL_W-1:0] = ctrl_r[0];
         `OCM_A_CTRL1: rdData[`OCM_CTRL_W-1:0] = ctrl_r[1];
         `OCM_A_ACT0:  rdData[7:0] = act_r[0];
         `OCM_A_ACT1:  rdData[7:0] = act_r[1];
         `OCM_A_STAT0: rdData[5:0] = stat_r[0];
         `OCM_A_STAT1: rdData[5:0] = stat_r[1];
         `OCM_A_CNT0:  rdData[CW-1:0] = cnt_r[0]; // RULE_04
         `OCM_A_CNT1:  rdData[CW-1:0] = cnt_r[1]; // RULE_04
         default: begin
            if (paddr[`OCM_GR_SEL] == `OCM_GR_TAG) begin
               rdData[CW-1:0] =
                  gr_r[paddr[`OCM_GR_CH]][paddr[`OCM_GR_IDX]];
            end else begin
               rdErr = 1'b1;
            end
         end
      endcase
   end

   // ***************************************************
   // control registers
   // ***************************************************
   // plain software fields
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stopSel_r  <= 2'h0;
         lockstep_r <= 1'b0;
         extRole_r  <= 2'h0;
         pioDir_r   <= 8'h00;
         pioDat_r   <= 8'h00;
         ctrl_r[0]  <= '0;
         ctrl_r[1]  <= '0;
         act_r[0]   <= 8'h00;
         act_r[1]   <= 8'h00;
      end else if (wr) begin
         case (paddr)
            `OCM_A_START: stopSel_r <= pwdata[`OCM_F_STOPSEL];
            `OCM_A_MODE: begin
               lockstep_r <= pwdata[`OCM_F_SYNC];
               extRole_r  <= pwdata[`OCM_F_EIROLE]; // RULE_03
            end
            `OCM_A_PIO: begin
               pioDir_r <= pwdata[`OCM_F_DIR];
               pioDat_r <= pwdata[`OCM_F_DAT];
            end
            `OCM_A_CTRL0: ctrl_r[0] <= pwdata[`OCM_CTRL_W-1:0];
            `OCM_A_CTRL1: ctrl_r[1] <= pwdata[`OCM_CTRL_W-1:0];
            `OCM_A_ACT0:  act_r[0] <= pwdata[7:0];
            `OCM_A_ACT1:  act_r[1] <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ***************************************************
   // count sources and the interrupt pin
   // ***************************************************
   // free prescaler and pin histories
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r     <= 5'h00;
         extPrev_r <= 1'b0;
         eiPrev_r  <= 1'b1;
      end else begin
         pre_r     <= pre_r + 5'h01;
         extPrev_r <= pinIn[0];
         eiPrev_r  <= extIntIn;
      end
   end
   // clock pin edge, only while ch0 pin A is the clock input
   assign extEdge = ctrl_r[0][`OCM_F_EXTCK] &&
                    (ctrl_r[0][`OCM_F_EDGE] ? (extPrev_r & ~pinIn[0])
                                            : (~extPrev_r & pinIn[0]));
   // low level on the pin cuts compare outputs off
   assign cutoff  = extRole_r == ocm_pkg::EI_CUTOFF && !extIntIn; // RULE_03
   assign eiEvent = extRole_r == ocm_pkg::EI_INT &&
                    eiPrev_r && !extIntIn;                       // RULE_03

   // ***************************************************
   // channels
   // ***************************************************
   for (genvar c = 0; c < 2; c++) begin : gCh
      localparam logic [7:0] MYCNT = c ? `OCM_A_CNT1 : `OCM_A_CNT0;
      localparam logic [7:0] OTCNT = c ? `OCM_A_CNT0 : `OCM_A_CNT1;
      localparam logic [7:0] MYST  = c ? `OCM_A_STAT1 : `OCM_A_STAT0;
      logic       tick;       // counter advances this cycle
      logic [3:0] hit;        // compare matches
      logic       ovf;        // wrap from all ones
      logic       cntWr;      // software load
      logic       startWr;    // start register written
      logic       go;         // start bit 0 -> 1
      logic [3:0] lvlNxt;
      logic [5:0] stClr;
      assign tick = start_r[c] && srcTick(
                       ctrl_r[c][`OCM_F_CKS], pre_r, extEdge,
                       fastOscTick);                             // RULE_15
      always_comb begin
         for (int j = 0; j < 4; j++) begin
            hit[j] = tick && cnt_r[c] == gr_r[c][j];
         end
      end
      assign ovf     = tick && &cnt_r[c];                        // RULE_19
      assign cntWr   = wr && (paddr == MYCNT ||
                              (lockstep_r && paddr == OTCNT)); // RULE_05 RULE_06
      assign startWr = wr && paddr == `OCM_A_START;
      assign go      = startWr && pwdata[c] && !start_r[c];
      // start bit; software write beats a match in the same cycle
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            start_r[c] <= 1'b0;
         end else if (startWr) begin
            start_r[c] <= pwdata[c];                     // RULE_16 RULE_12
         end else if (hit[0] && !stopSel_r[c]) begin
            start_r[c] <= 1'b0;                                  // RULE_13
         end
      end
      // counter
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            cnt_r[c] <= '0;
         end else if (cntWr) begin
            cnt_r[c] <= pwdata[CW-1:0];                  // RULE_05 RULE_06
         end else if (tick) begin
            // clear on A match when chosen, else wrap naturally
            cnt_r[c] <= (ctrl_r[c][`OCM_F_CLRA] && hit[0]) ? '0
                        : cnt_r[c] + 1'b1;               // RULE_09 RULE_19
         end
      end
      // general registers
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            for (int j = 0; j < 4; j++) begin
               gr_r[c][j] <= '0;
            end
         end else begin
            for (int j = 0; j < 4; j++) begin
               if (wr && isGr(paddr, c, j)) begin
                  gr_r[c][j] <= pwdata[CW-1:0];
               end
            end
         end
      end
      // next levels; C and D may act on pins A and B instead
      always_comb begin
         lvlNxt = lvl_r[c];
         for (int j = 0; j < 4; j++) begin
            if (j >= 2 && ctrl_r[c][`OCM_F_USE_LO + j - 2]) begin
               if (hit[j]) begin
                  lvlNxt[j-2] = applyAct(lvlNxt[j-2],
                                         act_r[c][2*j +: 2]); // RULE_10
               end
            end else if (hit[j]) begin
               lvlNxt[j] = applyAct(lvlNxt[j], act_r[c][2*j +: 2]); // RULE_07
            end
         end
      end
      // levels load their initial value at count start
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            lvl_r[c] <= 4'h0;
         end else if (go) begin
            lvl_r[c] <= ctrl_r[c][`OCM_F_INIT];                  // RULE_08
         end else begin
            lvl_r[c] <= lvlNxt;              // held when stopped, RULE_17
         end
      end
      // sticky events; a new event wins over a clear
      assign stClr = (wr && paddr == MYST) ? pwdata[5:0] : 6'h00;
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            stat_r[c] <= 6'h00;
            irqReq[c] <= 1'b0;
         end else begin
            stat_r[c] <= (stat_r[c] & ~stClr) |
                         {eiEvent && c == 0, ovf, hit};          // RULE_18
            irqReq[c] <= |stat_r[c];                             // RULE_18
         end
      end
      a_stop_on_match: assert property (@(posedge ref_clk) disable iff
         (!rst_n) hit[0] && !stopSel_r[c] && !startWr |=> !start_r[c])
         else $error("start bit kept after A match"); // RULE_13
      a_start_count: assert property (@(posedge ref_clk) disable iff
         (!rst_n) startWr && pwdata[c] |=> start_r[c])
         else $error("start write ignored"); // RULE_16
      a_clear_on_a: assert property (@(posedge ref_clk) disable iff
         (!rst_n) hit[0] && ctrl_r[c][`OCM_F_CLRA] && !cntWr
         |=> cnt_r[c] == '0)
         else $error("counter not cleared on A match"); // RULE_09
      a_wrap_flag: assert property (@(posedge ref_clk) disable iff
         (!rst_n) tick && &cnt_r[c] && !cntWr && !hit[0]
         |=> cnt_r[c] == '0 && stat_r[c][`OCM_ST_OVF])
         else $error("wrap without overflow flag"); // RULE_19
      a_hold_stop: assert property (@(posedge ref_clk) disable iff
         (!rst_n) !start_r[c] && !startWr |=> $stable(lvl_r[c]))
         else $error("level moved while stopped"); // RULE_17
      a_init_level: assert property (@(posedge ref_clk) disable iff
         (!rst_n) go |=> lvl_r[c] == $past(ctrl_r[c][`OCM_F_INIT]))
         else $error("initial level not loaded"); // RULE_08
      a_toggle_b: assert property (@(posedge ref_clk) disable iff
         (!rst_n) hit[1] && !go && !hit[3] &&
         act_r[c][3:2] == ocm_pkg::ACT_TOGGLE
         |=> lvl_r[c][1] == !$past(lvl_r[c][1]))
         else $error("pin B did not toggle"); // RULE_07
   end
   // ***************************************************
   // pins
   // ***************************************************
   for (genvar p = 0; p < 8; p++) begin : gPin
      localparam int C = p / 4;
      localparam int J = p % 4;
      logic clkRole;  // ch0 pin A given over to the clock input
      logic cmpRole;  // pin chosen as compare output
      assign clkRole = p == 0 && ctrl_r[0][`OCM_F_EXTCK];        // RULE_01
      assign cmpRole = ctrl_r[C][`OCM_F_PEN_LO + J] && !clkRole; // RULE_11
      // compare level or port data, registered onto the pin
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            pinOut[p] <= 1'b0;
            pinOe[p]  <= 1'b0;
         end else if (cmpRole) begin
            pinOut[p] <= lvl_r[C][J];                    // RULE_02 RULE_01
            pinOe[p]  <= !cutoff;                                // RULE_03
         end else begin
            pinOut[p] <= pioDat_r[p];                            // RULE_02
            pinOe[p]  <= pioDir_r[p] && !clkRole;                // RULE_01
         end
      end
   end
   // ***************************************************
   // bus checks
   // ***************************************************
   a_cnt_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      setup && !pwrite && paddr == `OCM_A_CNT0
      |=> prdata[CW-1:0] == $past(cnt_r[0]))
      else $error("counter read mismatch"); // RULE_04
   a_lock_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr && lockstep_r && paddr == `OCM_A_CNT0
      |=> cnt_r[1] == $past(pwdata[CW-1:0]))
      else $error("lockstep write missed ch1"); // RULE_06
   a_single_load: assert property (@(posedge ref_clk) disable iff
      (!rst_n) wr && !lockstep_r && paddr == `OCM_A_CNT0
      |=> cnt_r[1] == $past(cnt_r[1]) || cnt_r[1] == '0 ||
          cnt_r[1] == $past(cnt_r[1]) + 1'b1)
      else $error("independent write leaked to ch1"); // RULE_05
endmodule

// ---- sim/ocm_pin_load.sv ----
// load on the compare timer pads: resolves each pad level
// assumes one clock, pads released by the timer float
`timescale 1ns/1ps
module ocm_pin_load (
   input  wire logic       ref_clk,
   input  wire logic [7:0] pinOut,
   input  wire logic [7:0] pinOe,
   input  wire logic       extPullDown,
   output logic      [7:0] pinLvl,
   output logic            extIntLvl
);
   // ***************************************************
   // pad resolution
   // ***************************************************
   logic [7:0] floatLvl;   // level seen on released pads
   initial floatLvl = 8'hA5;
   // released pads wander each cycle so stale data never reads back
   always @(posedge ref_clk) begin
      floatLvl <= ~floatLvl;
   end
   // driven pads follow the timer, released ones float
   always_comb begin
      pinLvl = (pinOe & pinOut) | (~pinOe & floatLvl);
   end
   // interrupt pad has a pull-up; the bench may pull it low
   assign extIntLvl = !extPullDown;
endmodule

// ---- sim/dual_channel_output_compare_timer_tb.sv ----
// self-checking bench for the two-channel compare timer
// assumes zero-wait apb slave and the pad load model beside it
`timescale 1ns/1ps
module dual_channel_output_compare_timer_tb;
   logic        ref_clk, rst_n, psel, penable, pwrite, fastOscTick;
   logic [7:0]  paddr, pinIn, pinOut, pinOe;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, extIntIn, err, a0, lvl, extPullDown;
   logic [1:0]  irqReq, act;
   logic [15:0] v0, v1, gra;
   logic [3:0]  init, pen;
   logic [2:0]  src;
   int          errors, num_checks, k, n;

   ocm_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
      .extIntIn(extIntIn), .fastOscTick(fastOscTick), .pinOut(pinOut),
      .pinOe(pinOe), .irqReq(irqReq));
   ocm_pin_load load_u (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe),
      .extPullDown(extPullDown), .pinLvl(pinIn), .extIntLvl(extIntIn));

   // ***************************************************
   // clock and fast oscillator ticks
   // ***************************************************
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // random ticks so the fast source is exercised unevenly
   always @(posedge ref_clk) begin
      fastOscTick <= 1'($urandom % 2);
   end

   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
         errors++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   // one channel 0 run that stops itself on the A match
   task automatic run(input logic [15:0] ctrl, input logic [7:0] ac,
                      input logic [15:0] ga, input logic [15:0] gc);
      int i;
      apb(1'b1, 8'h10, {16'h0, ctrl});
      apb(1'b1, 8'h18, {24'h0, ac});
      apb(1'b1, 8'h40, {16'h0, ga});
      apb(1'b1, 8'h48, {16'h0, gc});
      apb(1'b1, 8'h28, 32'h0);
      apb(1'b1, 8'h20, 32'h3F);
      apb(1'b1, 8'h00, 32'h01);
      @(negedge ref_clk);
      chk(32'(pinOut[3:0]), 32'(ctrl[8:5] & ctrl[12:9]));
      chk(32'(pinOe[3:0]), 32'(ctrl[12:9]));
      @(posedge ref_clk);
      i = 0;
      do begin
         apb(1'b0, 8'h00, 32'h0);
         i++;
      end while (rd[0] !== 1'b0 && i < 400);
      chk(32'(rd[1:0]), 32'h0);
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      errors = 0;
      num_checks = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      extPullDown = 1'b0;
      void'($urandom(98313));
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, 8'h28, 32'h0);
      chk(rd, 32'h0);
      // unmapped offset: refused, write lost, reads zero
      apb(1'b1, 8'h30, 32'hFFFFFFFF);
      apb(1'b0, 8'h30, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
      // independent, then lockstep counter writes
      for (k = 0; k < 2; k++) begin
         v0 = 16'($urandom);
         v1 = 16'($urandom);
         apb(1'b1, 8'h04, 32'(k));
         apb(1'b1, 8'h28, {16'h0, v0});
         apb(1'b1, 8'h2C, {16'h0, v1});
         apb(1'b0, 8'h28, 32'h0);
         chk(rd, {16'h0, (k == 1) ? v1 : v0});
         apb(1'b0, 8'h2C, 32'h0);
         chk(rd, {16'h0, v1});
      end
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h4C, 32'hFFFF);
      // every action on pin A, toggle on B, under each divided and the fast count source
      for (k = 0; k < 6; k++) begin
         src = (k < 5) ? 3'(k) : 3'd6;
         act = 2'(1 + k % 3);
         init = 4'($urandom);
         pen = 4'($urandom) | 4'h1;
         gra = 16'(8 + $urandom % 13);
         run({3'b000, pen, init, 1'b1, 1'b0, src}, {4'h0, 2'h3, act}, gra,
             16'hFFFF);
         a0 = (act == 2'd1) ? 1'b0 : (act == 2'd2) ? 1'b1 : ~init[0];
         init[1] = ~init[1]; // pin B matched once, at count zero
         chk(32'(pinOut[3:0]), 32'({init[3:1], a0} & pen));
         apb(1'b0, 8'h28, 32'h0);
         chk(rd, 32'h0);
         apb(1'b0, 8'h20, 32'h0);
         chk(32'(rd[0]), 32'h1);
         chk(32'(irqReq[0]), 32'h1);
      end
      // register C steers pin A only when chosen
      for (k = 0; k < 2; k++) begin
         run({2'b00, 1'(k), 4'h1, 4'h0, 1'b1, 4'h0}, 8'h20, 16'd20, 16'd8);
         chk(32'(pinOut[0]), 32'(k));
      end
      // software-only stop: keeps counting past A, holds on stop
      apb(1'b1, 8'h10, 32'h0210);
      apb(1'b1, 8'h18, 32'h3);
      apb(1'b1, 8'h40, 32'd10);
      apb(1'b1, 8'h00, 32'h05);
      for (n = 0; n < 10; n++) apb(1'b0, 8'h00, 32'h0);
      chk(32'(rd[0]), 32'h1);
      apb(1'b1, 8'h00, 32'h04);
      @(posedge ref_clk);
      lvl = pinOut[0];
      apb(1'b0, 8'h28, 32'h0);
      v0 = rd[15:0];
      repeat (5) @(posedge ref_clk);
      apb(1'b0, 8'h28, 32'h0);
      chk(rd, {16'h0, v0});
      chk(32'(pinOut[0]), 32'(lvl));
      // interrupt pin: cutoff releases compare pins, then a falling edge
      apb(1'b1, 8'h04, 32'h2);
      extPullDown <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(32'(pinOe[0]), 32'h0);
      extPullDown <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(32'(pinOe[0]), 32'h1);
      apb(1'b1, 8'h04, 32'h4);
      apb(1'b1, 8'h20, 32'h3F);
      extPullDown <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, 8'h20, 32'h0);
      chk(32'(rd[5]), 32'h1);
      extPullDown <= 1'b0;
      // released ch0 pin A clocks the counter on its rising edges
      apb(1'b1, 8'h10, 32'h8205);
      apb(1'b1, 8'h28, 32'h0);
      apb(1'b1, 8'h00, 32'h05);
      repeat (20) @(posedge ref_clk);
      chk(32'(pinOe[0]), 32'h0);
      apb(1'b1, 8'h00, 32'h04);
      apb(1'b0, 8'h28, 32'h0);
      chk(32'(rd[15:0] inside {16'h000B, 16'h000C}), 32'h1);
      // free run across the top of the count
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h20, 32'h3F);
      apb(1'b1, 8'h28, 32'hFFF0);
      apb(1'b1, 8'h00, 32'h05);
      n = 0;
      do begin
         apb(1'b0, 8'h20, 32'h0);
         n++;
      end while (rd[4] !== 1'b1 && n < 30);
      chk(32'(rd[4]), 32'h1);
      apb(1'b0, 8'h28, 32'h0);
      chk(32'(rd[15:0] < 16'h0100), 32'h1);
      end_of_test();
   end
endmodule
